// File: ffm_field_margin.sv
// Purpose: Set-field-margin-level command sequencer with its registers
// Assumes: Register port on clk_i; mode pin synchronised here
// Notes:   One command in flight; register writes dropped while busy
// Function
// - Clearing the complete flag launches; margin applied and flag set again on the same edge.
// - EEPROM target applies margin to EEPROM reads only.
// - Program flash target applies margin to both arrays.
// - Level 0..4 decodes normal, user-1, user-0, field-1, field-0.
// - Margin-1 shifts toward erased, margin-0 toward programmed.
// - Index not 1 at launch sets access error, command skipped.
// - Launch in a mode without the command sets access error.
// - Invalid level encoding sets access error.
// - Interrupt request while complete flag and its enable are set.
`timescale 1ns/100ps
`default_nettype none
module ffm_field_margin
   import ffm_pkg::*;
#(
   parameter int SYNC_STAGES = 2
)
(
   input  wire logic                 clk_i,
   input  wire logic                 rst_n_i,
   input  wire logic [7:0]           addr_i,
   input  wire logic [7:0]           wdata_i,
   input  wire logic                 wr_i,
   input  wire logic                 rd_i,
   input  wire logic                 special_mode_i,
   output var  logic [7:0]           rdata_o,
   output var  ffm_pkg::ffm_margin_s pflash_margin_o,
   output var  ffm_pkg::ffm_margin_s eeprom_margin_o,
   output var  logic                 cmd_irq_o
);
   import ffm_pkg::*;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_CHECK,
      ST_APPLY
   } ffm_state_e;

   typedef struct packed {
      ffm_state_e       state;
      logic [SYNC_STAGES-1:0] mode_sync;
      logic [2:0]       param_slot_index;
      logic [15:0]      slot_cmd;
      logic [15:0]      slot_level;
      logic             command_complete_flag;
      logic             access_error_flag;
      logic             command_done_irq_en;
      logic [7:0]       eeprom_protection;
      logic [7:0]       clkdiv;
      ffm_margin_s      pflash_margin;
      ffm_margin_s      eeprom_margin;
      logic [7:0]       rdata;
      logic             irq;
   } ffm_regs_s;

   // Synchroniser depth the logic can serve
   if (SYNC_STAGES < 2 || SYNC_STAGES > 4)
   begin : g_sync_check
      $error("SYNC_STAGES must lie between 2 and 4");
   end

   // Reset state
   localparam ffm_margin_s MRG_RST = '{MRG_NORMAL, 1'b0, 1'b0};
   localparam ffm_regs_s   REGS_RST = '{
      state:                 ST_IDLE,
      mode_sync:             '0,
      param_slot_index:      3'h0,
      slot_cmd:              16'h0000,
      slot_level:            16'h0000,
      command_complete_flag: 1'b1,
      access_error_flag:     1'b0,
      command_done_irq_en:   1'b0,
      eeprom_protection:     RST_EEPROM_PROT,
      clkdiv:                8'h00,
      pflash_margin:         MRG_RST,
      eeprom_margin:         MRG_RST,
      rdata:                 8'h00,
      irq:                   1'b0
   };

   ffm_regs_s   r;
   ffm_regs_s   next_r;
   ffm_margin_s dec_margin;
   logic        dec_valid;

   ffm_level_decode u_dec (
      .word_i   (r.slot_level),
      .margin_o (dec_margin),
      .valid_o  (dec_valid)
   );

   function automatic logic [15:0] put_byte(input logic [15:0] w, input logic hi,
                                            input logic [7:0] b);
      put_byte = hi ? {b, w[7:0]} : {w[15:8], b};
   endfunction : put_byte

   function automatic logic [7:0] status_byte(input logic done, input logic acc_err);
      status_byte                 = 8'h00;
      status_byte[BIT_COMPLETE]   = done;
      status_byte[BIT_ACCESS_ERR] = acc_err;
      status_byte[BIT_PROT_VIOL]  = 1'b0;
      status_byte[BIT_RESULT_HI]  = 1'b0;
      status_byte[BIT_RESULT_LO]  = 1'b0;
   endfunction : status_byte

   function automatic logic [7:0] margin_byte(input ffm_margin_s ee, input ffm_margin_s pf);
      margin_byte = {1'b0, ee.level, 1'b0, pf.level};
   endfunction : margin_byte

   function automatic logic launch_fault(input logic [2:0] idx,
                                         input logic       mode_ok,
                                         input logic [7:0] code,
                                         input logic       level_ok);
      launch_fault = (idx != IDX_LEVEL)
                     || !mode_ok
                     || (code != CMD_FIELD_MARGIN)
                     || !level_ok;
   endfunction : launch_fault

   always_comb
   begin
      logic [15:0] sel_word;
      sel_word = (r.param_slot_index == IDX_CMD) ? r.slot_cmd : r.slot_level;
      next_r = r;
      // Mode pin synchroniser
      next_r.mode_sync = {r.mode_sync[SYNC_STAGES-2:0], special_mode_i};
      next_r.rdata = 8'h00;

      // Register reads
      if (rd_i)
      begin
         unique case (addr_i[4:0])
            OFS_CLKDIV:   next_r.rdata = r.clkdiv;
            OFS_IDX:      next_r.rdata = {5'h00, r.param_slot_index};
            OFS_CFG:      next_r.rdata = {r.command_done_irq_en, 7'h00};
            OFS_STAT:     next_r.rdata = status_byte(r.command_complete_flag,
                                                     r.access_error_flag);
            OFS_EEPROM_PROT: next_r.rdata = r.eeprom_protection;
            OFS_PARAM_HI: next_r.rdata = sel_word[15:8];
            OFS_PARAM_LO: next_r.rdata = sel_word[7:0];
            OFS_MARGIN:   next_r.rdata = margin_byte(r.eeprom_margin, r.pflash_margin);
            default:      next_r.rdata = 8'h00;
         endcase
      end

      // Register writes, dropped while busy
      if (wr_i && r.command_complete_flag)
      begin
         unique case (addr_i[4:0])
            OFS_CLKDIV: next_r.clkdiv = wdata_i;
            OFS_IDX:    next_r.param_slot_index = wdata_i[2:0];
            OFS_CFG:    next_r.command_done_irq_en = wdata_i[BIT_DONE_IRQ_EN];
            OFS_EEPROM_PROT: next_r.eeprom_protection = wdata_i;
            OFS_PARAM_HI, OFS_PARAM_LO:
            begin
               if (r.param_slot_index == IDX_CMD)
                  next_r.slot_cmd = put_byte(r.slot_cmd, addr_i[0] == 1'b0, wdata_i);
               else if (r.param_slot_index == IDX_LEVEL)
                  next_r.slot_level = put_byte(r.slot_level, addr_i[0] == 1'b0, wdata_i);
            end
            OFS_STAT:
            begin
               if (wdata_i[BIT_ACCESS_ERR])
                  next_r.access_error_flag = 1'b0;
               if (wdata_i[BIT_COMPLETE] && !r.access_error_flag && !wdata_i[BIT_ACCESS_ERR])
               begin
                  next_r.command_complete_flag = 1'b0;
                  next_r.state = ST_CHECK;
               end
            end
            default: ;
         endcase
      end

      // Command sequencer
      unique case (r.state)
         ST_IDLE: ;
         ST_CHECK:
         begin
            if (launch_fault(r.param_slot_index, r.mode_sync[SYNC_STAGES-1],
                             r.slot_cmd[15:8], dec_valid))
            begin
               next_r.access_error_flag = 1'b1;
               next_r.command_complete_flag = 1'b1;
               next_r.state = ST_IDLE;
            end
            else
               next_r.state = ST_APPLY;
         end
         ST_APPLY:
         begin
            if (r.slot_cmd[1:0] == BLK_EEPROM)
               next_r.eeprom_margin = dec_margin;
            else
            begin
               next_r.pflash_margin = dec_margin;
               next_r.eeprom_margin = dec_margin;
            end
            next_r.command_complete_flag = 1'b1;
            next_r.state = ST_IDLE;
         end
      endcase
      next_r.irq = next_r.command_complete_flag && next_r.command_done_irq_en;
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         r <= REGS_RST;
      else
         r <= next_r;
   end

   assign rdata_o         = r.rdata;
   assign pflash_margin_o = r.pflash_margin;
   assign eeprom_margin_o = r.eeprom_margin;
   assign cmd_irq_o       = r.irq;
endmodule : ffm_field_margin
`default_nettype wire

// File: ffm_field_margin_asserts.sv
// Purpose: Port checks for the margin block
// Assumes: Bound to ffm_field_margin
// Notes:   Launch history of four cycles
`timescale 1ns/100ps
`default_nettype none
module ffm_field_margin_asserts
   import ffm_pkg::*;
(
   input wire logic                 clk_i,
   input wire logic                 rst_n_i,
   input wire logic [7:0]           addr_i,
   input wire logic [7:0]           wdata_i,
   input wire logic                 wr_i,
   input wire logic                 rd_i,
   input wire logic                 special_mode_i,
   input wire logic [7:0]           rdata_o,
   input wire ffm_pkg::ffm_margin_s pflash_margin_o,
   input wire ffm_pkg::ffm_margin_s eeprom_margin_o,
   input wire logic                 cmd_irq_o
);
   logic       go;
   logic [3:0] hist;
   assign go = wr_i && addr_i[4:0] == OFS_STAT && wdata_i[BIT_COMPLETE];
   always_ff @(posedge clk_i or negedge rst_n_i)
      if (!rst_n_i)
         hist <= 4'h0;
      else
         hist <= {hist[2:0], go};
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   margin_cause_a: assert property ($changed(pflash_margin_o) || $changed(eeprom_margin_o)
      |-> |hist) else $error("margin moved without launch");
   pf_follow_a: assert property ($changed(pflash_margin_o)
      |-> eeprom_margin_o == pflash_margin_o) else $error("eeprom margin not shared");
   level_legal_a: assert property (pflash_margin_o.level <= MRG_FIELD0
      && eeprom_margin_o.level <= MRG_FIELD0) else $error("bad margin level");
   toward_erased_a: assert property (pflash_margin_o.toward_erased ==
      (pflash_margin_o.level inside {MRG_USER1, MRG_FIELD1})) else $error("erased shift");
   toward_prog_a: assert property (eeprom_margin_o.toward_programmed ==
      (eeprom_margin_o.level inside {MRG_USER0, MRG_FIELD0})) else $error("programmed shift");
   mode_block_a: assert property (!special_mode_i [*4] ##0 go
      |=> ($stable(pflash_margin_o) && $stable(eeprom_margin_o)) [*3])
      else $error("command ran in wrong mode");
   irq_cause_a: assert property ($rose(cmd_irq_o)
      |-> $past(wr_i) || $past(wr_i, 2) || $past(wr_i, 3)) else $error("irq rose unbidden");
   stat_clear_a: assert property ($past(rd_i) && $past(addr_i[4:0]) == OFS_STAT
      |-> rdata_o[4] == 1'b0 && rdata_o[1:0] == 2'h0) else $error("status bits set");
   cover property (go);
   cover property ($rose(cmd_irq_o));
   cover property ($changed(eeprom_margin_o));
endmodule : ffm_field_margin_asserts
bind ffm_field_margin ffm_field_margin_asserts ffm_field_margin_asserts_inst (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
   .rd_i(rd_i), .special_mode_i(special_mode_i), .rdata_o(rdata_o), .cmd_irq_o(cmd_irq_o),
   .pflash_margin_o(pflash_margin_o), .eeprom_margin_o(eeprom_margin_o));
`default_nettype wire

// File: ffm_field_margin_tb.sv
// Purpose: Self-checking bench for the margin block
// Assumes: Command completes two cycles after launch
// Notes:   Random levels include illegal codes
`timescale 1ns/100ps
`default_nettype none
module ffm_field_margin_tb;
   import ffm_pkg::*;
   logic        clk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic [7:0]  addr_i = 8'h00;
   logic [7:0]  wdata_i = 8'h00;
   logic        wr_i = 1'b0;
   logic        rd_i = 1'b0;
   logic        special_mode_i = 1'b1;
   logic [7:0]  rdata_o, d;
   ffm_margin_s pflash_margin_o, eeprom_margin_o, pf_x, ee_x;
   logic        cmd_irq_o, bad;
   logic [2:0]  lvl;
   logic [1:0]  blk;
   int          err_total = 0;
   int          cmp_count = 0;
   always #2 clk_i = ~clk_i;
   ffm_field_margin ffm_field_margin_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .special_mode_i(special_mode_i), .pflash_margin_o(pflash_margin_o),
      .eeprom_margin_o(eeprom_margin_o), .cmd_irq_o(cmd_irq_o));
   task automatic end_of_test();
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : end_of_test
   task automatic cmp(input logic [7:0] g, input logic [7:0] e);
      cmp_count++;
      if (g !== e)
      begin
         err_total++;
         $display("wrong value at %0t got %h exp %h", $time, g, e);
      end
   endtask : cmp
   task automatic wr(input logic [4:0] a, input logic [7:0] v);
      @(posedge clk_i);
      addr_i <= {3'h0, a};
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [4:0] a);
      @(posedge clk_i);
      addr_i <= {3'h0, a};
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask : rd
   function automatic ffm_margin_s em(input logic [2:0] l);
      em.level = ffm_level_e'(l);
      em.toward_erased = l == 3'h1 || l == 3'h3;
      em.toward_programmed = l == 3'h2 || l == 3'h4;
   endfunction : em
   initial
   begin
      void'($urandom(32'hecd5171e));
      repeat (12) @(posedge clk_i);
      rst_n_i <= 1'b1;
      pf_x = em(3'h0);
      ee_x = pf_x;
      rd(OFS_EEPROM_PROT);
      cmp(d, RST_EEPROM_PROT);
      wr(OFS_EEPROM_PROT, 8'ha5);
      rd(OFS_EEPROM_PROT);
      cmp(d, 8'ha5);
      wr(OFS_CLKDIV, 8'h3c);
      rd(OFS_CLKDIV);
      cmp(d, 8'h3c);
      rd(5'h1f);
      cmp(d, 8'h00);
      wr(OFS_CFG, 8'h80);
      repeat (3) @(negedge clk_i);
      cmp({7'h0, cmd_irq_o}, 8'h01);
      for (int i = 0; i < 24; i++)
      begin
         lvl = (i < 7) ? i[2:0] : 3'($urandom_range(0, 6));
         blk = 2'($urandom);
         special_mode_i <= (i != 8);
         bad = (i == 8) || (i == 9) || (i == 10) || (lvl > 3'h4);
         wr(OFS_IDX, {5'h0, IDX_CMD});
         wr(OFS_PARAM_HI, (i == 10) ? 8'h0d : CMD_FIELD_MARGIN);
         wr(OFS_PARAM_LO, {6'h0, blk});
         wr(OFS_IDX, {5'h0, IDX_LEVEL});
         wr(OFS_PARAM_HI, 8'h00);
         wr(OFS_PARAM_LO, {5'h0, lvl});
         if (i == 9)
            wr(OFS_IDX, 8'h02);
         wr(OFS_STAT, 8'h80);
         rd(OFS_STAT);
         cmp(d, {bad, 1'b0, bad, 5'h00});
         if (!bad)
         begin
            ee_x = em(lvl);
            if (blk != BLK_EEPROM)
               pf_x = ee_x;
         end
         rd(OFS_STAT);
         cmp(d, {2'h2, bad, 5'h00});
         cmp({3'h0, pflash_margin_o}, {3'h0, pf_x});
         cmp({3'h0, eeprom_margin_o}, {3'h0, ee_x});
         cmp({7'h0, cmd_irq_o}, 8'h01);
         rd(OFS_MARGIN);
         cmp(d, {1'b0, ee_x.level, 1'b0, pf_x.level});
         wr(OFS_STAT, 8'h20);
      end
      wr(OFS_CFG, 8'h00);
      repeat (3) @(negedge clk_i);
      cmp({7'h0, cmd_irq_o}, 8'h00);
      end_of_test();
   end
   initial
   begin
      repeat (20000) @(posedge clk_i);
      err_total++;
      end_of_test();
   end
endmodule : ffm_field_margin_tb
`default_nettype wire

// File: ffm_level_decode.sv
// Purpose: Decode a margin level word into a level and read shift
// Assumes: Purely combinational
// Notes:   valid_o low for unknown encodings
`timescale 1ns/100ps
`default_nettype none
module ffm_level_decode
   import ffm_pkg::*;
(
   input  wire logic [15:0]            word_i,
   output var  ffm_pkg::ffm_margin_s   margin_o,
   output var  logic                   valid_o
);
   always_comb
   begin
      margin_o = '{level: MRG_NORMAL, toward_erased: 1'b0, toward_programmed: 1'b0};
      valid_o  = 1'b1;
      unique case (word_i)
         LVL_NORMAL: margin_o.level = MRG_NORMAL;
         LVL_USER1:  margin_o = '{MRG_USER1, 1'b1, 1'b0};
         LVL_USER0:  margin_o = '{MRG_USER0, 1'b0, 1'b1};
         LVL_FIELD1: margin_o = '{MRG_FIELD1, 1'b1, 1'b0};
         LVL_FIELD0: margin_o = '{MRG_FIELD0, 1'b0, 1'b1};
         default:    valid_o = 1'b0;
      endcase
   end
endmodule : ffm_level_decode
`default_nettype wire

// File: ffm_pkg.sv
// Purpose: Constants and carriers for the field margin command block
// Assumes: 8-bit register port, byte offsets as listed
// Notes:   Parameter buffer words are 16 bits wide
package ffm_pkg;
   localparam logic [4:0]  OFS_CLKDIV   = 5'h00;
   localparam logic [4:0]  OFS_IDX      = 5'h02;
   localparam logic [4:0]  OFS_CFG      = 5'h04;
   localparam logic [4:0]  OFS_STAT     = 5'h06;
   localparam logic [4:0]  OFS_EEPROM_PROT = 5'h09;
   localparam logic [4:0]  OFS_PARAM_HI = 5'h0a;
   localparam logic [4:0]  OFS_PARAM_LO = 5'h0b;
   localparam logic [4:0]  OFS_MARGIN   = 5'h10;
   localparam logic [7:0]  CMD_FIELD_MARGIN = 8'h0e;
   localparam logic [2:0]  IDX_CMD      = 3'h0;
   localparam logic [2:0]  IDX_LEVEL    = 3'h1;
   localparam logic [1:0]  BLK_EEPROM   = 2'h1;
   localparam logic [15:0] LVL_NORMAL   = 16'h0000;
   localparam logic [15:0] LVL_USER1    = 16'h0001;
   localparam logic [15:0] LVL_USER0    = 16'h0002;
   localparam logic [15:0] LVL_FIELD1   = 16'h0003;
   localparam logic [15:0] LVL_FIELD0   = 16'h0004;
   localparam logic [7:0]  RST_EEPROM_PROT = 8'h00;
   localparam int          BIT_COMPLETE    = 7;
   localparam int          BIT_ACCESS_ERR  = 5;
   localparam int          BIT_PROT_VIOL   = 4;
   localparam int          BIT_RESULT_HI   = 1;
   localparam int          BIT_RESULT_LO   = 0;
   localparam int          BIT_DONE_IRQ_EN = 7;

   typedef enum logic [2:0] {
      MRG_NORMAL, MRG_USER1, MRG_USER0, MRG_FIELD1, MRG_FIELD0
   } ffm_level_e;

   typedef struct packed {
      logic       [7:0] addr;
      logic       [7:0] wdata;
      logic             wr;
      logic             rd;
   } ffm_bus_s;

   typedef struct packed {
      ffm_level_e       level;
      logic             toward_erased;
      logic             toward_programmed;
   } ffm_margin_s;
endpackage : ffm_pkg
